/* File: pkg/fnd_pkg.sv */
// constants and state types for the fractional divide-by-n.f core
package fnd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // serial ratio word layout
  localparam int unsigned WORD_BITS   = 40;
  localparam int unsigned DIGIT_BITS  = 4;
  localparam int unsigned INT_DIGITS  = 3;
  localparam int unsigned FRAC_DIGITS = 6;
  localparam int unsigned BCD_DIGITS  = INT_DIGITS + FRAC_DIGITS;
  localparam int unsigned CTRL_BITS   = 4;
  localparam int unsigned FRAC_W      = FRAC_DIGITS * DIGIT_BITS;
  localparam int unsigned INT_W       = INT_DIGITS * DIGIT_BITS;
  localparam int unsigned FRAC_LSB    = 0;
  localparam int unsigned INT_LSB     = FRAC_LSB + FRAC_W;
  localparam int unsigned CTRL_LSB    = INT_LSB + INT_W;
  localparam int unsigned BAND_LSB    = 0;
  localparam int unsigned BAND_BITS   = 2;
  localparam int unsigned BW_LSB      = BAND_LSB + BAND_BITS;
  localparam int unsigned BW_BITS     = 2;

  ////////////////////////////////////////////////////////////////////////////
  // divider and interpolation widths
  localparam int unsigned N_WIDTH     = 10;
  localparam int unsigned INTERP_BITS = 5;

  ////////////////////////////////////////////////////////////////////////////
  // decimal arithmetic constants
  localparam logic [4:0]         BCD_MAX_W    = 5'h0_9;
  localparam logic [4:0]         BCD_TEN_W    = 5'h0_A;
  localparam logic [3:0]         BCD_MAX      = 4'h9;
  localparam logic [N_WIDTH-1:0] DEC_HUNDRED  = 10'h0_64;
  localparam logic [N_WIDTH-1:0] DEC_TEN      = 10'h0_0A;
  localparam logic [N_WIDTH-1:0] N_ONE        = 10'h0_01;
  localparam logic [N_WIDTH-1:0] N_ZERO       = 10'h0_00;
  localparam logic [FRAC_W-1:0]  ACC_EMPTY    = 24'h00_0000;
  localparam logic [WORD_BITS-1:0] WORD_CLEAR = 40'h00_0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // divider state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } fnd_state_t;

  typedef struct packed {
    logic [WORD_BITS-1:0] shift;
  } fnd_link_t;

  typedef struct packed {
    fnd_state_t             state;
    logic                   strobe_s1;
    logic                   strobe_s2;
    logic                   strobe_s3;
    logic [CTRL_BITS-1:0]   ctrl;
    logic [N_WIDTH-1:0]     n_val;
    logic [FRAC_W-1:0]      frac;
    logic [FRAC_W-1:0]      accum;
    logic [N_WIDTH-1:0]     count;
    logic                   swallow_pend;
    logic                   div_pulse;
    logic                   swallow_pulse;
    logic                   overflow_pulse;
    logic                   word_error;
    logic [INTERP_BITS-1:0] interp;
  } fnd_sys_t;

endpackage

/* File: rtl/fnd_divider.sv */
// fractional divide-by-n.f digital core with serial ratio word input
//
// Summary of operation
// - count oscillator pulses, pulse out every N
// - add fraction to accumulator on each output
// - accumulator starts empty when division begins
// - on overflow drop one cycle, keep remainder
// - exact one cycle overflows to zero
// - overflow swallows the next oscillator pulse
// - swallow cycle spans N plus one pulses
// - average ratio equals N plus F
// - fraction kept in cycles, not degrees
// - six fraction digits give 0.1 Hz steps
// - N range covers 40.469 to 70.455 MHz
// - 40 bits shifted, latched on strobe fall
// - word holds nine bcd digits, four controls
// - five interpolation bits, msd first, lsd last
`timescale 1ns/100ps

module fnd_divider
  import fnd_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 ce_i,
  input  wire logic                 osc_pulse_i,
  input  wire logic                 link_clk_i,
  input  wire logic                 link_data_i,
  input  wire logic                 link_strobe_i,
  output logic                      div_pulse_o,
  output logic                      swallow_o,
  output logic                      overflow_o,
  output logic                      running_o,
  output logic                      word_error_o,
  output logic [BAND_BITS-1:0]      band_sel_o,
  output logic [BW_BITS-1:0]        loop_bw_o,
  output logic [N_WIDTH-1:0]        ratio_int_o,
  output logic [FRAC_W-1:0]         ratio_frac_o,
  output logic [FRAC_W-1:0]         accum_o,
  output logic                      interp_bit_msd_o,
  output logic                      interp_bit_2nd_o,
  output logic                      interp_bit_3rd_o,
  output logic                      interp_bit_4th_o,
  output logic                      interp_bit_lsd_o
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain: serial shift register
  fnd_link_t lnk_reg;
  fnd_link_t lnk_next;

  always_comb begin
    lnk_next       = lnk_reg;
    lnk_next.shift = {lnk_reg.shift[WORD_BITS-2:0], link_data_i};
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lnk_reg.shift <= WORD_CLEAR;
    end else begin
      lnk_reg <= lnk_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain state
  fnd_sys_t r_reg;
  fnd_sys_t r_next;

  logic [WORD_BITS-1:0] word;
  logic                 strobe_fall;
  logic [BCD_DIGITS-1:0] digit_bad;
  logic                 word_ok;
  logic [N_WIDTH-1:0]   n_decoded;
  logic [N_WIDTH-1:0]   n_last;
  logic [FRAC_W-1:0]    acc_sum;
  logic [FRAC_DIGITS:0] carry;
  logic                 acc_overflow;
  logic [FRAC_DIGITS-1:0] acc_digit_nz;

  // word is held still by the controller once the strobe has gone high
  assign word        = lnk_reg.shift;
  assign strobe_fall = r_reg.strobe_s3 & ~r_reg.strobe_s2;

  ////////////////////////////////////////////////////////////////////////////
  // bcd digit check of the captured word
  genvar gd;
  generate
    for (gd = 0; gd < BCD_DIGITS; gd++) begin : g_chk
      assign digit_bad[gd] = word[FRAC_LSB + gd*DIGIT_BITS +: DIGIT_BITS] > BCD_MAX;
    end
  endgenerate

  assign word_ok = ~|digit_bad;

  ////////////////////////////////////////////////////////////////////////////
  // integer part: three bcd digits to binary
  logic [N_WIDTH-1:0] int_d2;
  logic [N_WIDTH-1:0] int_d1;
  logic [N_WIDTH-1:0] int_d0;
  logic [2*N_WIDTH-1:0] int_p2;
  logic [2*N_WIDTH-1:0] int_p1;

  assign int_d2 = {{(N_WIDTH-DIGIT_BITS){1'b0}}, word[INT_LSB + 2*DIGIT_BITS +: DIGIT_BITS]};
  assign int_d1 = {{(N_WIDTH-DIGIT_BITS){1'b0}}, word[INT_LSB + DIGIT_BITS +: DIGIT_BITS]};
  assign int_d0 = {{(N_WIDTH-DIGIT_BITS){1'b0}}, word[INT_LSB +: DIGIT_BITS]};
  assign int_p2 = int_d2 * DEC_HUNDRED;
  assign int_p1 = int_d1 * DEC_TEN;

  // up to 999, enough for 404..704 at a 100 kHz reference
  assign n_decoded = int_p2[N_WIDTH-1:0] + int_p1[N_WIDTH-1:0] + int_d0;

  // a ratio of zero is run as divide by one
  assign n_last = (r_reg.n_val == N_ZERO) ? N_ZERO : r_reg.n_val - N_ONE;

  ////////////////////////////////////////////////////////////////////////////
  // decimal phase accumulator adder, one digit per stage
  assign carry[0] = 1'b0;

  genvar ga;
  generate
    for (ga = 0; ga < FRAC_DIGITS; ga++) begin : g_add
      logic [4:0] raw;
      logic [4:0] fixed;
      assign raw = {1'b0, r_reg.accum[ga*DIGIT_BITS +: DIGIT_BITS]}
                 + {1'b0, r_reg.frac[ga*DIGIT_BITS +: DIGIT_BITS]}
                 + {4'h0, carry[ga]};
      assign carry[ga+1] = raw > BCD_MAX_W;
      assign fixed = carry[ga+1] ? raw - BCD_TEN_W : raw;
      assign acc_sum[ga*DIGIT_BITS +: DIGIT_BITS] = fixed[DIGIT_BITS-1:0];
      assign acc_digit_nz[ga] = |r_reg.accum[ga*DIGIT_BITS +: DIGIT_BITS];
    end
  endgenerate

  // carry out of the tenths digit is one whole oscillator cycle
  assign acc_overflow = carry[FRAC_DIGITS];

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    r_next                = r_reg;
    r_next.strobe_s1      = link_strobe_i;
    r_next.strobe_s2      = r_reg.strobe_s1;
    r_next.strobe_s3      = r_reg.strobe_s2;
    r_next.div_pulse      = 1'b0;
    r_next.swallow_pulse  = 1'b0;
    r_next.overflow_pulse = 1'b0;

    // interpolation bits follow the top five accumulator digits
    for (int i = 0; i < INTERP_BITS; i++) begin
      r_next.interp[i] = acc_digit_nz[FRAC_DIGITS - INTERP_BITS + i];
    end

    case (r_reg.state)
      ST_IDLE: begin
        r_next.count        = N_ZERO;
        r_next.accum        = ACC_EMPTY;
        r_next.swallow_pend = 1'b0;
      end
      ST_RUN: begin
        if (osc_pulse_i) begin
          if (r_reg.swallow_pend) begin
            // pulse removed before the counter sees it
            r_next.swallow_pend  = 1'b0;
            r_next.swallow_pulse = 1'b1;
          end else if (r_reg.count >= n_last) begin
            r_next.count     = N_ZERO;
            r_next.div_pulse = 1'b1;
            r_next.accum     = acc_sum;
            if (acc_overflow) begin
              r_next.swallow_pend   = 1'b1;
              r_next.overflow_pulse = 1'b1;
            end
          end else begin
            r_next.count = r_reg.count + N_ONE;
          end
        end
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase

    // new valid word: latch fields and restart the divider cleanly, bad word sets word_error
    if (strobe_fall) begin
      if (word_ok) begin
        r_next.ctrl         = word[CTRL_LSB +: CTRL_BITS];
        r_next.n_val        = n_decoded;
        r_next.frac         = word[FRAC_LSB +: FRAC_W];
        r_next.count        = N_ZERO;
        r_next.accum        = ACC_EMPTY;
        r_next.swallow_pend = 1'b0;
        r_next.div_pulse    = 1'b0;
        r_next.overflow_pulse = 1'b0;
        r_next.swallow_pulse  = 1'b0;
        r_next.word_error   = 1'b0;
        r_next.state        = ST_RUN;
      end else begin
        r_next.word_error = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      r_reg.state          <= ST_IDLE;
      r_reg.strobe_s1      <= 1'b0;
      r_reg.strobe_s2      <= 1'b0;
      r_reg.strobe_s3      <= 1'b0;
      r_reg.ctrl           <= {CTRL_BITS{1'b0}};
      r_reg.n_val          <= N_ZERO;
      r_reg.frac           <= ACC_EMPTY;
      r_reg.accum          <= ACC_EMPTY;
      r_reg.count          <= N_ZERO;
      r_reg.swallow_pend   <= 1'b0;
      r_reg.div_pulse      <= 1'b0;
      r_reg.swallow_pulse  <= 1'b0;
      r_reg.overflow_pulse <= 1'b0;
      r_reg.word_error     <= 1'b0;
      r_reg.interp         <= {INTERP_BITS{1'b0}};
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign div_pulse_o      = r_reg.div_pulse;
  assign swallow_o        = r_reg.swallow_pulse;
  assign overflow_o       = r_reg.overflow_pulse;
  assign running_o        = r_reg.state == ST_RUN;
  assign word_error_o     = r_reg.word_error;
  assign band_sel_o       = r_reg.ctrl[BAND_LSB +: BAND_BITS];
  assign loop_bw_o        = r_reg.ctrl[BW_LSB +: BW_BITS];
  assign ratio_int_o      = r_reg.n_val;
  assign ratio_frac_o     = r_reg.frac;
  assign accum_o          = r_reg.accum;
  assign interp_bit_msd_o = r_reg.interp[INTERP_BITS-1];
  assign interp_bit_2nd_o = r_reg.interp[INTERP_BITS-2];
  assign interp_bit_3rd_o = r_reg.interp[INTERP_BITS-3];
  assign interp_bit_4th_o = r_reg.interp[INTERP_BITS-4];
  assign interp_bit_lsd_o = r_reg.interp[0];

endmodule

/* File: sim/fnd_ctrl_model.sv */
// control processor model that shifts ratio words over the serial link
`timescale 1ns/100ps
module fnd_ctrl_model (
  output logic link_clk_o,
  output logic link_data_o,
  output logic link_strobe_o
);
  initial begin
    link_clk_o = 1'b0;
    link_data_o = 1'b1;
    link_strobe_o = 1'b0;
  end
  // caller builds the word from the wanted frequency plus offset
  task automatic send(input logic [39:0] w);
    #7;
    for (int i = 39; i >= 0; i--) begin
      link_data_o = w[i];
      #16 link_clk_o = 1'b1;
      #16 link_clk_o = 1'b0;
    end
    link_data_o = ~w[0];
    #20 link_strobe_o = 1'b1;
    #64 link_strobe_o = 1'b0;
    #100;
  endtask
endmodule

/* File: sim/fnd_sva.sv */
// assertion checker for the fractional divider outputs
`timescale 1ns/100ps
module fnd_sva
  import fnd_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              reset_i,
  input wire logic              ce_i,
  input wire logic              div_pulse_o,
  input wire logic              swallow_o,
  input wire logic              overflow_o,
  input wire logic              running_o,
  input wire logic              word_error_o,
  input wire logic [FRAC_W-1:0] accum_o,
  input wire logic              interp_bit_msd_o,
  input wire logic              interp_bit_lsd_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_ovf_with_div: assert property (overflow_o |-> div_pulse_o)
    else $error("overflow without divider pulse");
  a_acc_change: assert property ($changed(accum_o) |-> div_pulse_o || accum_o == ACC_EMPTY)
    else $error("accumulator moved without divider pulse");
  a_acc_grows: assert property (div_pulse_o && !overflow_o |-> accum_o >= $past(accum_o))
    else $error("accumulator shrank without overflow");
  a_ovf_wraps: assert property (overflow_o && $past(ce_i) |-> accum_o < $past(accum_o))
    else $error("overflow kept a full cycle");
  a_acc_digits: assert property (accum_o[23:20] <= 4'h9 && accum_o[3:0] <= 4'h9)
    else $error("accumulator digit not decimal");
  a_idle_quiet: assert property (!running_o |-> !div_pulse_o && !swallow_o)
    else $error("divider active while idle");
  a_interp_msd: assert property ($past(ce_i) |-> interp_bit_msd_o == ($past(accum_o[23:20]) != 4'h0))
    else $error("msd interpolation bit wrong");
  a_interp_lsd: assert property ($past(ce_i) |-> interp_bit_lsd_o == ($past(accum_o[7:4]) != 4'h0))
    else $error("lsd interpolation bit wrong");
  a_swallow_sep: assert property (swallow_o |=> !swallow_o || !$past(ce_i))
    else $error("two swallows back to back");
  c_overflow: cover property (overflow_o);
  c_swallow: cover property (swallow_o);
  c_word_error: cover property ($rose(word_error_o));
endmodule

bind fnd_divider fnd_sva u_sva (.sys_clk_i, .reset_i, .ce_i, .div_pulse_o, .swallow_o, .overflow_o, .running_o,
  .word_error_o, .accum_o, .interp_bit_msd_o, .interp_bit_lsd_o);

/* File: sim/tb.sv */
// self-checking bench for the fractional divider with a reference model
`timescale 1ns/100ps
module tb;
  import fnd_pkg::*;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, osc_pulse_i = 1'b0, gate = 1'b1;
  logic link_clk, link_data, link_strobe, div_p, sw_p, ovf_p, run, werr;
  logic [1:0] band, bw;
  logic [N_WIDTH-1:0] rint;
  logic [FRAC_W-1:0] rfrac, acc_o;
  logic [4:0] ib;
  int seed = 85174, mismatches = 0, cmp_count = 0;
  int cnt = 0, sw_cnt = 0, acc = 0, pend = 0, n_m = 0, f_m = 0;
  int nt[5] = '{5, 3, 519, 704, 404};
  int ft[5] = '{375000, 500000, 375000, 549999, 690000};

  fnd_ctrl_model ctrl (.link_clk_o(link_clk), .link_data_o(link_data), .link_strobe_o(link_strobe));
  fnd_divider DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .ce_i(ce_i), .osc_pulse_i(osc_pulse_i),
    .link_clk_i(link_clk), .link_data_i(link_data), .link_strobe_i(link_strobe), .div_pulse_o(div_p),
    .swallow_o(sw_p), .overflow_o(ovf_p), .running_o(run), .word_error_o(werr), .band_sel_o(band),
    .loop_bw_o(bw), .ratio_int_o(rint), .ratio_frac_o(rfrac), .accum_o(acc_o), .interp_bit_msd_o(ib[4]),
    .interp_bit_2nd_o(ib[3]), .interp_bit_3rd_o(ib[2]), .interp_bit_4th_o(ib[1]), .interp_bit_lsd_o(ib[0]));

  initial forever #5 sys_clk_i = ~sys_clk_i;

  function automatic logic [39:0] bcd(input int v);
    logic [39:0] r;
    r = '0;
    for (int i = 0; i < 10; i++) begin
      r[4*i+:4] = v % 10;
      v = v / 10;
    end
    return r;
  endfunction

  task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // reference divider, sampled where outputs are settled; ce_i and osc_pulse_i
  // still hold what the last rising edge used, frozen edges are skipped
  always @(negedge sys_clk_i) begin
    if (run === 1'b1 && ce_i === 1'b1) begin
      if (osc_pulse_i === 1'b1) cnt++;
      if (div_p === 1'b1) begin
        check("span", cnt, n_m + pend);
        check("swallowed", sw_cnt, pend);
        acc += f_m;
        pend = (acc >= 1000000);
        if (pend) acc -= 1000000;
        check("accum", acc_o, bcd(acc));
        check("overflow", ovf_p, pend);
        cnt = 0;
        sw_cnt = 0;
      end
      if (sw_p === 1'b1) sw_cnt++;
    end
    ce_i <= gate || (($random(seed) & 3) != 0);
    osc_pulse_i <= !gate && (($random(seed) & 3) != 0);
  end

  task automatic load(input int n, input int f);
    logic [39:0] w;
    w = bcd(n * 1000000 + f);
    w[39:36] = $random(seed);
    @(negedge sys_clk_i) gate = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    ctrl.send(w);
    repeat (2) @(negedge sys_clk_i);
    cnt = 0;
    sw_cnt = 0;
    acc = 0;
    pend = 0;
    n_m = n;
    f_m = f;
    check("running", run, 1'b1);
    check("ratio_int", rint, n);
    check("ratio_frac", rfrac, bcd(f));
    check("band", band, w[37:36]);
    check("bw", bw, w[39:38]);
    check("accum_clear", acc_o, 40'h00_0000_0000);
    gate = 1'b0;
  endtask

  initial begin
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i) reset_i = 1'b0;
    for (int k = 0; k < 5; k++) begin
      load(nt[k], ft[k]);
      repeat ((nt[k] + 2) * 14) @(negedge sys_clk_i);
    end
    @(negedge sys_clk_i) gate = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    ctrl.send({4'h0, 12'hA00, 24'h00_0000});
    check("word_error", werr, 1'b1);
    check("int_kept", rint, nt[4]);
    tally_and_finish();
  end

  initial begin
    #600_000;
    mismatches++;
    tally_and_finish();
  end
endmodule
